//--- inc/i2c_addr_pkg.sv
package i2c_addr_pkg;
    localparam int          DATA_W          = 32;
    localparam int          ADDR_W          = 8;
    localparam int          TADDR_W         = 10;
    // Register byte offsets
    localparam logic [7:0]  OFF_ENABLE      = 8'h00;
    localparam logic [7:0]  OFF_TARGET      = 8'h04;
    localparam logic [7:0]  OFF_OWN         = 8'h08;
    localparam logic [7:0]  OFF_CTRL        = 8'h0c;
    localparam logic [7:0]  OFF_STATUS      = 8'h10;
    localparam logic [7:0]  OFF_MASK        = 8'h14;
    localparam logic [7:0]  OFF_INFO        = 8'h18;
    // Target register fields
    localparam int          TGT_WIDTH_BIT   = 12;
    localparam int          TGT_SPECIAL_BIT = 11;
    localparam int          TGT_GCSB_BIT    = 10;
    localparam logic [9:0]  ADDR_RESET      = 10'h055;
    localparam int          ENABLE_BIT      = 0;
    localparam int          OWN_WIDTH_BIT   = 0;
    localparam int          LOW7_W          = 7;
    // Event status bits
    localparam int          EV_GC_READ_BIT  = 0;
    localparam int          EV_TX_ABORT_BIT = 6;
    localparam int          EV_RD_REQ_BIT   = 5;
    localparam int          EV_W            = 7;
    localparam logic [7:0]  GC_ADDR_BYTE    = 8'h00;
    localparam logic [7:0]  START_BYTE      = 8'h01;
    localparam logic [4:0]  TEN_BIT_PREFIX  = 5'h1e;

    typedef enum logic [2:0] {
        ADDR_NORMAL = 3'b001,
        ADDR_GCALL  = 3'b010,
        ADDR_STARTB = 3'b100
    } addr_mode_t;

    typedef struct packed {
        logic       valid;
        logic       rd;
    } cmd_t;

    typedef struct packed {
        logic       valid;
        logic       ten_bit;
        logic [9:0] addr;
        logic       rd;
    } slave_hdr_t;
endpackage : i2c_addr_pkg

//--- design/i2c_addr_match.sv
`timescale 1ns/1ps
module i2c_addr_match #(
    parameter int TW = i2c_addr_pkg::TADDR_W
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_rst_b,
    input  wire logic                    i_ce,
    input  wire logic                    i_ten_bit_mode,
    input  wire logic [TW-1:0]           i_own_addr,
    input  wire i2c_addr_pkg::slave_hdr_t i_hdr,
    output logic                         o_match,
    output logic                         o_match_rd
);
    import i2c_addr_pkg::*;

    // Header address is fixed at ten bits, so the own field must match it
    if (TW != TADDR_W) begin : g_bad_width
        $error("address width must equal the header width");
    end

    logic hit;
    always_comb begin
        if (i_ten_bit_mode) begin
            hit = i_hdr.ten_bit && (i_hdr.addr == i_own_addr);
        end else begin
            hit = !i_hdr.ten_bit
                  && (i_hdr.addr[LOW7_W-1:0] == i_own_addr[LOW7_W-1:0]);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_match    <= 1'b0;
            o_match_rd <= 1'b0;
        end else if (i_ce) begin
            o_match    <= i_hdr.valid && hit;
            o_match_rd <= i_hdr.valid && hit && i_hdr.rd;
        end
    end

    AST_MATCH_MODE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_ce && i_hdr.valid && (i_hdr.ten_bit != i_ten_bit_mode) |=> !o_match)
        else $error("match across address widths");
endmodule : i2c_addr_match

//--- design/i2c_address_config.sv
`timescale 1ns/1ps
// Behaviour
// - Master width bit picks 10 or 7-bit
// - Width bit exists only with runtime option
// - Special bit enables broadcast/start-byte select
// - Select one is START byte, zero General Call
// - Read after General Call sets abort
// - General Call holds until special cleared or select set to one
// - Target field addresses, ignored during General Call
// - Own-address loopback is simplex only
// - Own address resets 0x055, low seven match
// - Own-address writes only while disabled
// - Own change after read request rearms
// - Slave width bit selects match width
module i2c_address_config #(
    parameter bit RUNTIME_TARGET_UPDATE = 1'b1
) (
    input  wire logic                          i_clk,
    input  wire logic                          i_rst_b,
    input  wire logic                          i_ce,
    input  wire logic                          i_psel,
    input  wire logic                          i_penable,
    input  wire logic                          i_pwrite,
    input  wire logic [i2c_addr_pkg::ADDR_W-1:0] i_paddr,
    input  wire logic [i2c_addr_pkg::DATA_W-1:0] i_pwdata,
    output logic      [i2c_addr_pkg::DATA_W-1:0] o_prdata,
    output logic                               o_pready,
    output logic                               o_pslverr,
    input  wire i2c_addr_pkg::cmd_t            i_cmd,
    input  wire i2c_addr_pkg::slave_hdr_t      i_slave_hdr,
    input  wire logic                          i_rd_req_event,
    output logic                               o_first_byte_valid,
    output logic      [7:0]                    o_first_byte,
    output logic      [7:0]                    o_second_byte,
    output logic                               o_ten_bit_master,
    output logic                               o_cmd_accept,
    output logic                               o_slave_match,
    output logic                               o_slave_match_rd,
    output logic                               o_self_loop,
    output logic                               o_irq
);
    import i2c_addr_pkg::*;

    logic [TADDR_W-1:0] tgt_addr_r;
    logic               tgt_width_r;
    logic               tgt_special_r;
    logic               tgt_gcsb_r;
    logic [TADDR_W-1:0] own_addr_r;
    logic               enable_r;
    logic               own_width_r;
    logic [EV_W-1:0]    status_r;
    logic [EV_W-1:0]    mask_r;
    logic               rd_req_seen_r;
    logic               own_changed_r;
    logic               enable_d_r;
    addr_mode_t         mode;

    ////////////////////////////////////////////////////////////////////////
    logic wr_en;
    logic rd_en;
    logic rd_load;
    logic rd_primed_r;
    assign wr_en     = i_ce && i_psel && i_penable && i_pwrite;
    // One wait state on reads: data loads at the first access edge
    // and stands in its flip-flops when the master samples it
    assign rd_load   = i_psel && i_penable && !i_pwrite && !rd_primed_r;
    assign rd_en     = i_ce && rd_load;
    // Frozen clock enable stalls the bus rather than dropping a write
    assign o_pready  = i_ce && (i_pwrite || rd_primed_r);

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            rd_primed_r <= 1'b0;
        end else if (i_ce) begin
            rd_primed_r <= rd_load;
        end
    end

    logic mapped;
    always_comb begin
        case (i_paddr)
            OFF_ENABLE, OFF_TARGET, OFF_OWN, OFF_CTRL,
            OFF_STATUS, OFF_MASK, OFF_INFO: mapped = 1'b1;
            default:                        mapped = 1'b0;
        endcase
    end
    assign o_pslverr = i_psel && i_penable && !mapped;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            tgt_addr_r    <= ADDR_RESET;
            tgt_width_r   <= 1'b0;
            tgt_special_r <= 1'b0;
            tgt_gcsb_r    <= 1'b0;
        end else if (wr_en && i_paddr == OFF_TARGET) begin
            tgt_addr_r    <= i_pwdata[TADDR_W-1:0];
            tgt_width_r   <= RUNTIME_TARGET_UPDATE && i_pwdata[TGT_WIDTH_BIT];
            tgt_special_r <= i_pwdata[TGT_SPECIAL_BIT];
            tgt_gcsb_r    <= i_pwdata[TGT_GCSB_BIT];
        end
    end

    // Own address freezes while the interface runs
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            own_addr_r <= ADDR_RESET;
        end else if (wr_en && i_paddr == OFF_OWN && !enable_r) begin
            own_addr_r <= i_pwdata[TADDR_W-1:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            enable_r    <= 1'b0;
            own_width_r <= 1'b0;
            mask_r      <= '0;
        end else if (wr_en) begin
            if (i_paddr == OFF_ENABLE) enable_r    <= i_pwdata[ENABLE_BIT];
            if (i_paddr == OFF_CTRL)   own_width_r <= i_pwdata[OWN_WIDTH_BIT];
            if (i_paddr == OFF_MASK)   mask_r      <= i_pwdata[EV_W-1:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_prdata <= '0;
        end else if (rd_en) begin
            o_prdata <= '0;
            case (i_paddr)
                OFF_ENABLE: o_prdata[ENABLE_BIT] <= enable_r;
                OFF_TARGET: o_prdata[TGT_WIDTH_BIT:0] <= {tgt_width_r, tgt_special_r,
                                                         tgt_gcsb_r, tgt_addr_r};
                OFF_OWN:    o_prdata[TADDR_W-1:0] <= own_addr_r;
                OFF_CTRL:   o_prdata[OWN_WIDTH_BIT] <= own_width_r;
                OFF_STATUS: o_prdata[EV_W-1:0] <= status_r;
                OFF_MASK:   o_prdata[EV_W-1:0] <= mask_r;
                OFF_INFO:   o_prdata[0] <= RUNTIME_TARGET_UPDATE;
                default:    o_prdata <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        if (!tgt_special_r)  mode = ADDR_NORMAL;
        else if (tgt_gcsb_r) mode = ADDR_STARTB;
        else                 mode = ADDR_GCALL;
    end

    assign o_ten_bit_master = tgt_width_r;

    logic gc_read;
    assign gc_read      = i_cmd.valid && i_cmd.rd && (mode == ADDR_GCALL);
    assign o_cmd_accept = i_cmd.valid && !gc_read;

    // Address bytes reload on every enabled cycle; target field is unused for GC
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_first_byte_valid <= 1'b0;
            o_first_byte       <= '0;
            o_second_byte      <= '0;
        end else if (i_ce) begin
            o_first_byte_valid <= o_cmd_accept && enable_r;
            case (mode)
                ADDR_GCALL: begin
                    o_first_byte  <= GC_ADDR_BYTE;
                    o_second_byte <= '0;
                end
                ADDR_STARTB: begin
                    o_first_byte  <= START_BYTE;
                    o_second_byte <= tgt_addr_r[7:0];
                end
                ADDR_NORMAL: begin
                    if (tgt_width_r) begin
                        o_first_byte  <= {TEN_BIT_PREFIX, tgt_addr_r[9:8], 1'b0};
                        o_second_byte <= tgt_addr_r[7:0];
                    end else begin
                        o_first_byte  <= {tgt_addr_r[LOW7_W-1:0], i_cmd.rd};
                        o_second_byte <= '0;
                    end
                end
                default: begin
                    o_first_byte  <= '0;
                    o_second_byte <= '0;
                end
            endcase
        end
    end

    // Equal addresses in normal addressing: flag simplex loopback so the controller blocks duplex
    assign o_self_loop = (tgt_addr_r == own_addr_r) && (mode == ADDR_NORMAL);

    ////////////////////////////////////////////////////////////////////////
    i2c_addr_match #(
        .TW (TADDR_W)
    ) u_match (
        .i_clk          (i_clk),
        .i_rst_b        (i_rst_b),
        .i_ce           (i_ce),
        .i_ten_bit_mode (own_width_r),
        .i_own_addr     (own_addr_r),
        .i_hdr          (i_slave_hdr),
        .o_match        (o_slave_match),
        .o_match_rd     (o_slave_match_rd)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read-request rearm after own address change
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            rd_req_seen_r <= 1'b0;
            own_changed_r <= 1'b0;
            enable_d_r    <= 1'b0;
        end else if (i_ce) begin
            enable_d_r <= enable_r;
            if (i_rd_req_event) rd_req_seen_r <= 1'b1;
            if (wr_en && i_paddr == OFF_OWN && !enable_r && rd_req_seen_r)
                own_changed_r <= 1'b1;
            else if (enable_r && !enable_d_r)
                own_changed_r <= 1'b0;
        end
    end

    logic rearm;
    assign rearm = i_ce && enable_r && !enable_d_r && own_changed_r;

    logic [EV_W-1:0] ev_set;
    always_comb begin
        ev_set = '0;
        ev_set[EV_TX_ABORT_BIT] = i_ce && gc_read;
        ev_set[EV_GC_READ_BIT]  = i_ce && gc_read;
        ev_set[EV_RD_REQ_BIT]   = (i_ce && i_rd_req_event) || rearm;
    end

    // Set wins over write-one-to-clear
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            status_r <= '0;
        end else if (wr_en && i_paddr == OFF_STATUS) begin
            status_r <= (status_r & ~i_pwdata[EV_W-1:0]) | ev_set;
        end else begin
            status_r <= status_r | ev_set;
        end
    end

    assign o_irq = |(status_r & mask_r);

    ////////////////////////////////////////////////////////////////////////
    sequence s_gc_read_cmd;
        i_ce && i_cmd.valid && i_cmd.rd && tgt_special_r && !tgt_gcsb_r;
    endsequence

    sequence s_abort_raised;
        status_r[EV_TX_ABORT_BIT] && status_r[EV_GC_READ_BIT];
    endsequence

    AST_GC_READ_ABORT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        s_gc_read_cmd |=> s_abort_raised)
        else $error("read in general call did not abort");
    AST_GC_NO_ACCEPT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        tgt_special_r && !tgt_gcsb_r && i_cmd.rd |-> !o_cmd_accept)
        else $error("read accepted in general call");
    AST_OWN_LOCK: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        enable_r |=> $stable(own_addr_r))
        else $error("own address changed while enabled");
    AST_WIDTH_ABSENT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        wr_en && i_paddr == OFF_TARGET
        |=> o_ten_bit_master
            == (RUNTIME_TARGET_UPDATE && $past(i_pwdata[TGT_WIDTH_BIT])))
        else $error("target width bit not as written");
    AST_GC_BYTE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_ce && tgt_special_r && !tgt_gcsb_r |=> o_first_byte == GC_ADDR_BYTE)
        else $error("general call byte wrong");
    AST_START_BYTE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_ce && tgt_special_r && tgt_gcsb_r |=> o_first_byte == START_BYTE)
        else $error("start byte wrong");
    AST_TEN_BIT_HDR: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_ce && !tgt_special_r && tgt_width_r
        |=> o_first_byte[7:3] == TEN_BIT_PREFIX)
        else $error("ten-bit header missing");
    AST_NORMAL_7BIT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_ce && !tgt_special_r && !tgt_width_r
        |=> o_first_byte[7:1] == $past(tgt_addr_r[LOW7_W-1:0]))
        else $error("seven-bit address wrong");
    AST_REARM: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        rearm |=> status_r[EV_RD_REQ_BIT])
        else $error("read request not rearmed");
    AST_LOOP: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !tgt_special_r && tgt_addr_r == own_addr_r |-> o_self_loop)
        else $error("loopback not flagged");
    AST_SELF_LOOP_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        tgt_special_r |-> !o_self_loop)
        else $error("loopback flagged for a special command");
    // Reserved upper bits of every readable register stay zero
    AST_RESERVED_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        rd_en |=> o_prdata[DATA_W-1:TGT_WIDTH_BIT+1] == '0)
        else $error("reserved read bits not zero");
    AST_CMD_WRITE_OK: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_cmd.valid && !i_cmd.rd |-> o_cmd_accept)
        else $error("write command refused");
    AST_NORMAL_ACCEPT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !tgt_special_r && i_cmd.valid |-> o_cmd_accept)
        else $error("command refused in normal addressing");
    AST_TARGET_LAND: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        wr_en && i_paddr == OFF_TARGET |=> tgt_addr_r == $past(i_pwdata[TADDR_W-1:0]))
        else $error("target field write lost");
    AST_START_SECOND: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_ce && tgt_special_r && tgt_gcsb_r
        |=> o_second_byte == $past(tgt_addr_r[7:0]))
        else $error("start byte target byte wrong");
endmodule : i2c_address_config

//--- sim/i2c_far_model.sv
`timescale 1ns/1ps
module i2c_far_model (
    input  wire logic                     i_clk,
    output i2c_addr_pkg::cmd_t            o_cmd,
    output i2c_addr_pkg::slave_hdr_t      o_hdr,
    output logic                          o_rd_req
);
    import i2c_addr_pkg::*;
    logic       cmd_go, cmd_rd, hdr_go, rq_go;
    slave_hdr_t hdr_nxt;
    initial begin
        {cmd_go, cmd_rd, hdr_go, rq_go, o_rd_req} = '0;
        hdr_nxt = '0;
        o_cmd   = '0;
        o_hdr   = '0;
    end
    ////////////////////////////////////////////////////////////////////////////
    task put_cmd(input logic rd);
        cmd_go = 1'b1;
        cmd_rd = rd;
    endtask : put_cmd
    // Callers only name non-reserved addresses
    task put_hdr(input logic ten, input logic [9:0] a, input logic rd);
        hdr_go  = 1'b1;
        hdr_nxt = '{1'b1, ten, a, rd};
    endtask : put_hdr
    task put_rd_req();
        rq_go = 1'b1;
    endtask : put_rd_req
    // One-cycle pulses; idle fields flip so stale values never look valid
    always @(posedge i_clk) begin
        o_cmd    <= '{cmd_go, cmd_go ? cmd_rd : ~o_cmd.rd};
        o_hdr    <= hdr_go ? hdr_nxt : '{1'b0, ~o_hdr.ten_bit, ~o_hdr.addr, ~o_hdr.rd};
        o_rd_req <= rq_go;
        cmd_go = 1'b0;
        hdr_go = 1'b0;
        rq_go  = 1'b0;
    end
endmodule : i2c_far_model

//--- sim/i2c_address_config_bench.sv
`timescale 1ns/1ps
module i2c_address_config_bench;
    import i2c_addr_pkg::*;
    logic        i_clk = 0, i_rst_b = 0, psel = 0, pen = 0, pwrite = 0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic        pready, pslverr, e, fbv, acc, ten_m, sm, smr, loop_o, irq;
    logic [7:0]  fb, sb;
    cmd_t        cmd;
    slave_hdr_t  hdr;
    logic        rdq;
    int          num_errors = 0, comparisons = 0;
    logic [12:0] tv [5] = '{13'h0056, 13'h0456, 13'h0c56, 13'h1256, 13'h0800};
    logic        rv [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    logic [7:0]  fv [5] = '{8'hac, 8'had, START_BYTE, 8'hf4, GC_ADDR_BYTE};
    logic        sv [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic        hc [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic        ht [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    logic [9:0]  ha [4] = '{10'h2d5, 10'h056, 10'h055, 10'h055};
    logic        hr [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    logic        hx [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    always #2.5 i_clk = ~i_clk;
    i2c_far_model far (.i_clk(i_clk), .o_cmd(cmd), .o_hdr(hdr), .o_rd_req(rdq));
    i2c_address_config #(.RUNTIME_TARGET_UPDATE(1'b1)) uut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(1'b1), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_cmd(cmd), .i_slave_hdr(hdr),
        .i_rd_req_event(rdq), .o_first_byte_valid(fbv), .o_first_byte(fb),
        .o_second_byte(sb), .o_ten_bit_master(ten_m), .o_cmd_accept(acc),
        .o_slave_match(sm), .o_slave_match_rd(smr), .o_self_loop(loop_o), .o_irq(irq));
    ////////////////////////////////////////////////////////////////////////////
    task stop_test();
        $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            num_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask : chk
    // Request holds until pready; read data is taken at that same edge
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge i_clk);
        pen <= 1'b1;
        @(posedge i_clk);
        while (pready !== 1'b1) @(posedge i_clk);
        e = pslverr;
        q = prdata;
        psel <= 1'b0;
        pen  <= 1'b0;
        #1;
    endtask : xfer
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task rdc(input logic [7:0] a, input logic [31:0] x);
        xfer(1'b0, a, '0);
        chk(q, x);
    endtask : rdc
    task rdbit(input logic [7:0] a, input int b, input logic x);
        xfer(1'b0, a, '0);
        chk(32'(q[b]), 32'(x));
    endtask : rdbit
    task cmdc(input logic rd, input logic xa, input logic [7:0] xf, input logic xs);
        far.put_cmd(rd);
        @(posedge i_clk);
        #1 chk(32'(acc), 32'(xa));
        @(posedge i_clk);
        #1 chk(32'(fbv), 32'(xa));
        if (xa) chk(32'(fb), 32'(xf));
        if (xs) chk(32'(sb), 32'h56);
    endtask : cmdc
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge i_clk);
        num_errors++;
        stop_test();
    end
    initial begin
        repeat (16) @(posedge i_clk);
        i_rst_b <= 1;
        rdc(OFF_TARGET, 32'h055);
        rdc(OFF_OWN, 32'h055);
        wr(OFF_TARGET, 32'hffffffff);
        rdc(OFF_TARGET, 32'h1fff);
        wr(OFF_OWN, 32'hffffffff);
        rdc(OFF_OWN, 32'h3ff);
        wr(8'h1c, 32'h1);
        chk(32'(e), 32'h1);
        rdc(8'h1c, 32'h0);
        wr(OFF_OWN, 32'h055);
        wr(OFF_TARGET, 32'h055);
        chk(32'(loop_o), 32'h1);
        wr(OFF_ENABLE, 32'h1);
        wr(OFF_OWN, 32'h066);
        rdc(OFF_OWN, 32'h055);
        for (int i = 0; i < 5; i++) begin
            wr(OFF_TARGET, 32'(tv[i]));
            chk(32'(ten_m), 32'(tv[i][12]));
            chk(32'(loop_o), 32'h0);
            cmdc(rv[i], 1'b1, fv[i], sv[i]);
        end
        // Read after a broadcast is refused and raises the abort event
        cmdc(1'b1, 1'b0, 8'h00, 1'b0);
        rdbit(OFF_STATUS, EV_TX_ABORT_BIT, 1'b1);
        cmdc(1'b0, 1'b1, GC_ADDR_BYTE, 1'b0);
        wr(OFF_MASK, 32'h40);
        chk(32'(irq), 32'h1);
        wr(OFF_MASK, 32'h0);
        chk(32'(irq), 32'h0);
        wr(OFF_MASK, 32'h40);
        wr(OFF_STATUS, 32'h40);
        chk(32'(irq), 32'h0);
        rdbit(OFF_STATUS, EV_TX_ABORT_BIT, 1'b0);
        wr(OFF_TARGET, 32'h056);
        cmdc(1'b0, 1'b1, 8'hac, 1'b0);
        for (int i = 0; i < 4; i++) begin
            wr(OFF_CTRL, 32'(hc[i]));
            far.put_hdr(ht[i], ha[i], hr[i]);
            repeat (2) @(posedge i_clk);
            #1 chk(32'(sm), 32'(hx[i]));
            chk(32'(smr), 32'(hx[i] & hr[i]));
        end
        far.put_rd_req();
        rdbit(OFF_STATUS, EV_RD_REQ_BIT, 1'b1);
        wr(OFF_STATUS, 32'h20);
        rdbit(OFF_STATUS, EV_RD_REQ_BIT, 1'b0);
        wr(OFF_ENABLE, 32'h0);
        wr(OFF_OWN, 32'h05a);
        wr(OFF_ENABLE, 32'h1);
        rdbit(OFF_STATUS, EV_RD_REQ_BIT, 1'b1);
        rdc(OFF_OWN, 32'h05a);
        stop_test();
    end
endmodule : i2c_address_config_bench
